// >>> hw/mbw_pkg.sv
// Purpose: Constants, types and helpers for the register-write command block
// Assumes: Message bytes arrive already decoded from the serial link
// Notes: Register map holds one aligned 32-bit word per register
package mbw_pkg;
   // Message layout
   localparam int MAX_LEN = 9;
   localparam logic [3:0] LEN16 = 4'h7;
   localparam logic [3:0] LEN32 = 4'h9;
   localparam logic [3:0] EXC_LEN = 4'h4;
   localparam int IDX_ADDR = 0;
   localparam int IDX_FUNC = 1;
   localparam int IDX_REG_HI = 2;
   localparam int IDX_REG_LO = 3;
   localparam int IDX_DATA = 4;
   localparam logic [7:0] FUNC_WRITE_SINGLE = 8'h06;
   localparam logic [7:0] EXC_FLAG = 8'h80;
   localparam logic [7:0] EXC_ILLEGAL_ADDR = 8'h02;
   // Address ranges
   localparam int NUM_RANGES = 3;
   localparam logic [1:0] RANGE_INT16 = 2'h0;
   localparam logic [1:0] RANGE_INT32 = 2'h1;
   localparam logic [1:0] RANGE_FLOAT = 2'h2;
   // Storage
   localparam int BYTE_W = 8;
   localparam int MEM_AW = 8;
   localparam int BLOCK_AW = 6;
   localparam int MEM_WORDS = 256;
   localparam logic [17:0] OFF_LIMIT = 18'h00100;
   localparam int OFF_HALF_BIT = 1;
   localparam int OFF_WORD_LSB = 2;
   localparam logic [3:0] BE_HIGH_HALF = 4'hc;
   localparam logic [3:0] BE_LOW_HALF = 4'h3;
   localparam logic [3:0] BE_FULL = 4'hf;
   // Register map
   localparam int ADDR_W = 8;
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_RANGE_INT16 = 8'h04;
   localparam logic [7:0] REG_RANGE_INT32 = 8'h08;
   localparam logic [7:0] REG_RANGE_FLOAT = 8'h0c;
   localparam logic [7:0] REG_BLOCKS = 8'h10;
   localparam logic [7:0] REG_COUNTS = 8'h14;
   localparam logic [7:0] REG_LAST = 8'h18;
   localparam logic [7:0] REG_MEM_ADDR = 8'h1c;
   localparam logic [7:0] REG_MEM_DATA = 8'h20;
   localparam int WORD_SHIFT = 2;
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_ADDR_LSB = 8;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {ST_COLLECT, ST_CHECK, ST_WRITE, ST_REPLY} fsm_t;

   function automatic logic in_range(input logic [15:0] num, input logic [15:0] lo,
                                     input logic [15:0] hi);
      in_range = (num >= lo) && (num <= hi);
   endfunction

   function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] strb);
      strb_merge = old;
      for (int i = 0; i < 4; i++)
      begin
         if (strb[i])
            strb_merge[i*BYTE_W +: BYTE_W] = nw[i*BYTE_W +: BYTE_W];
      end
   endfunction
endpackage

// >>> hw/lrc_sum.sv
// Purpose: Running 8-bit sum of message bytes for the LRC check
// Assumes: clear and add never high together
// Notes: A frame with correct LRC sums to zero including the LRC byte
`timescale 1ns/1ps
module lrc_sum
   import mbw_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Byte input
   input wire logic clear,
   input wire logic add,
   input wire logic [7:0] data,
   // Result
   output logic [7:0] sum
);
   typedef struct packed {
      logic [7:0] sum;
   } lrc_regs_t;

   lrc_regs_t r;
   lrc_regs_t next_r;

   always_comb
   begin
      next_r = r;
      if (clear)
         next_r.sum = 8'h00;
      else if (add)
         next_r.sum = r.sum + data;
   end

   always_ff @(posedge clk)
   begin
      if (!reset_n)
         r <= '0;
      else
         r <= next_r;
   end

   assign sum = r.sum;
endmodule // lrc_sum

// >>> hw/storage_ram.sv
// Purpose: Word storage for the three data blocks, byte-lane writes
// Assumes: Address is block index above word index
// Notes: Read data registered, one cycle behind raddr
`timescale 1ns/1ps
module storage_ram
   import mbw_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Write port
   input wire logic we,
   input wire logic [3:0] be,
   input wire logic [MEM_AW-1:0] waddr,
   input wire logic [31:0] wdata,
   // Read port
   input wire logic [MEM_AW-1:0] raddr,
   output logic [31:0] rdata
);
   typedef struct packed {
      logic [31:0] rdata;
   } ram_regs_t;

   ram_regs_t r;
   ram_regs_t next_r;
   logic [31:0] mem [0:MEM_WORDS-1];

   always_comb
   begin
      next_r = r;
      next_r.rdata = mem[raddr];
   end

   always_ff @(posedge clk)
   begin
      if (!reset_n)
         r <= '0;
      else
         r <= next_r;
   end

   always_ff @(posedge clk)
   begin
      for (int i = 0; i < 4; i++)
      begin
         if (we && be[i])
            mem[waddr][i*BYTE_W +: BYTE_W] <= wdata[i*BYTE_W +: BYTE_W];
      end
   end

   assign rdata = r.rdata;
endmodule // storage_ram

// >>> hw/modbus_write_single_register_32bit.sv
// Purpose: Slave handling of the write-single-register request, 16/32-bit
// Assumes: Link bytes come binary from same-clock logic, last marks LRC
// Notes: Config and status over AXI4-Lite; storage readable via window
//
// The placing of the registers and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module modbus_write_single_register_32bit
   import mbw_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // AXI4-Lite write
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Request bytes from link
   input wire logic [7:0] rx_data,
   input wire logic rx_valid,
   input wire logic rx_last,
   output logic rx_ready,
   // Reply bytes to link
   output logic [7:0] tx_data,
   output logic tx_valid,
   output logic tx_last,
   input wire logic tx_ready
);
   typedef struct packed {
      fsm_t fsm;
      logic [MAX_LEN-1:0][7:0] frame;
      logic [3:0] count;
      logic overflow;
      logic [1:0] sel;
      logic [17:0] off;
      logic [3:0] tx_idx;
      logic [3:0] tx_len;
      logic tx_valid;
      logic [7:0] tx_data;
      logic enable;
      logic [7:0] slave_addr;
      logic [NUM_RANGES-1:0][15:0] lo;
      logic [NUM_RANGES-1:0][15:0] hi;
      logic [NUM_RANGES-1:0][7:0] blk;
      logic [MEM_AW-1:0] mem_addr;
      logic [7:0] n_write;
      logic [7:0] n_drop;
      logic [7:0] n_exc;
      logic [15:0] last_off;
      logic [7:0] last_blk;
      logic aw_held;
      logic w_held;
      logic [ADDR_W-1:0] aw_addr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } regs_t;

   localparam regs_t REGS_RESET = '0;

   regs_t r;
   regs_t next_r;
   logic [7:0] lrc;
   logic rx_hs;
   logic [15:0] regnum;
   logic [NUM_RANGES-1:0] hit;
   logic [1:0] sel;
   logic [15:0] diff;
   logic [17:0] off;
   logic [3:0] want_len;
   logic frame_ok;
   logic fits;
   logic [7:0] exc_lrc;
   logic [1:0] ri;
   logic [31:0] wv;
   logic [31:0] ctrl_word;
   logic mem_we;
   logic [3:0] mem_be;
   logic [MEM_AW-1:0] mem_waddr;
   logic [31:0] mem_wdata;
   logic [31:0] mem_rdata;

   assign rx_hs = rx_valid && (r.fsm == ST_COLLECT);
   assign ctrl_word = {16'h0000, r.slave_addr, 7'h00, r.enable};

   always_comb
   begin
      next_r = r;
      ri = '0;
      wv = '0;
      regnum = {r.frame[IDX_REG_HI], r.frame[IDX_REG_LO]};
      for (int i = 0; i < NUM_RANGES; i++)
         hit[i] = in_range(regnum, r.lo[i], r.hi[i]);
      sel = RANGE_FLOAT;
      if (hit[RANGE_INT32])
         sel = RANGE_INT32;
      if (hit[RANGE_INT16])
         sel = RANGE_INT16;
      diff = regnum - r.lo[sel];
      off = (sel == RANGE_INT16) ? {1'h0, diff, 1'h0} : {diff, 2'h0};
      want_len = (sel == RANGE_INT16) ? LEN16 : LEN32;
      fits = off < OFF_LIMIT;
      // discard on bad LRC or bad header
      frame_ok = r.enable && !r.overflow && (r.count == LEN16 || r.count == LEN32)
         && lrc == 8'h00 && r.frame[IDX_ADDR] == r.slave_addr
         && r.frame[IDX_FUNC] == FUNC_WRITE_SINGLE;
      exc_lrc = 8'h00 - (r.frame[IDX_ADDR] + (FUNC_WRITE_SINGLE | EXC_FLAG) + EXC_ILLEGAL_ADDR);

      case (r.fsm)
         ST_COLLECT:
         begin
            if (rx_hs)
            begin
               if (r.count < LEN32)
                  next_r.frame[r.count] = rx_data;
               else
                  next_r.overflow = 1'b1;
               if (r.count != 4'hf)
                  next_r.count = r.count + 4'h1;
               if (rx_last)
                  next_r.fsm = ST_CHECK;
            end
         end
         ST_CHECK:
         begin
            next_r.count = '0;
            next_r.overflow = 1'b0;
            next_r.fsm = ST_COLLECT;
            next_r.tx_idx = '0;
            next_r.tx_data = r.frame[IDX_ADDR];
            if (!frame_ok)
               next_r.n_drop = r.n_drop + 8'h01;
            else if (hit != '0 && fits)
            begin
               if (r.count == want_len)
               begin
                  next_r.sel = sel;
                  next_r.off = off;
                  next_r.tx_len = r.count;
                  next_r.fsm = ST_WRITE;
               end
               else
                  next_r.n_drop = r.n_drop + 8'h01;
            end
            else
            begin
               next_r.frame[IDX_FUNC] = FUNC_WRITE_SINGLE | EXC_FLAG;
               next_r.frame[IDX_REG_HI] = EXC_ILLEGAL_ADDR;
               next_r.frame[IDX_REG_LO] = exc_lrc;
               next_r.tx_len = EXC_LEN;
               next_r.tx_valid = 1'b1;
               next_r.n_exc = r.n_exc + 8'h01;
               next_r.fsm = ST_REPLY;
            end
         end
         ST_WRITE:
         begin
            next_r.n_write = r.n_write + 8'h01;
            next_r.last_off = r.off[15:0];
            next_r.last_blk = r.blk[r.sel];
            next_r.tx_valid = 1'b1;
            next_r.fsm = ST_REPLY;
         end
         ST_REPLY:
         begin
            if (tx_ready)
            begin
               if (r.tx_idx == r.tx_len - 4'h1)
               begin
                  next_r.tx_valid = 1'b0;
                  next_r.fsm = ST_COLLECT;
               end
               else
               begin
                  next_r.tx_idx = r.tx_idx + 4'h1;
                  next_r.tx_data = r.frame[r.tx_idx + 4'h1];
               end
            end
         end
         default:
            next_r.fsm = ST_COLLECT;
      endcase

      // AXI write channel
      if (r.bvalid && s_axi_bready)
         next_r.bvalid = 1'b0;
      if (s_axi_awvalid && s_axi_awready)
      begin
         next_r.aw_held = 1'b1;
         next_r.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         next_r.w_held = 1'b1;
         next_r.wdata = s_axi_wdata;
         next_r.wstrb = s_axi_wstrb;
      end
      if (r.aw_held && r.w_held)
      begin
         next_r.aw_held = 1'b0;
         next_r.w_held = 1'b0;
         next_r.bvalid = 1'b1;
         next_r.bresp = RESP_OKAY;
         case (r.aw_addr)
            REG_CTRL:
            begin
               wv = strb_merge(ctrl_word, r.wdata, r.wstrb);
               next_r.enable = wv[CTRL_EN_BIT];
               next_r.slave_addr = wv[CTRL_ADDR_LSB +: 8];
            end
            REG_RANGE_INT16, REG_RANGE_INT32, REG_RANGE_FLOAT:
            begin
               ri = 2'((r.aw_addr - REG_RANGE_INT16) >> WORD_SHIFT);
               wv = strb_merge({r.hi[ri], r.lo[ri]}, r.wdata, r.wstrb);
               next_r.lo[ri] = wv[15:0];
               next_r.hi[ri] = wv[31:16];
            end
            REG_BLOCKS:
            begin
               wv = strb_merge({8'h00, r.blk}, r.wdata, r.wstrb);
               next_r.blk = wv[23:0];
            end
            REG_MEM_ADDR:
            begin
               wv = strb_merge({24'h000000, r.mem_addr}, r.wdata, r.wstrb);
               next_r.mem_addr = wv[MEM_AW-1:0];
            end
            REG_COUNTS, REG_LAST, REG_MEM_DATA:
               next_r.bresp = RESP_OKAY;
            default:
               next_r.bresp = RESP_SLVERR;
         endcase
      end

      // AXI read channel
      if (r.rvalid && s_axi_rready)
         next_r.rvalid = 1'b0;
      else if (s_axi_arvalid && !r.rvalid)
      begin
         next_r.rvalid = 1'b1;
         next_r.rresp = RESP_OKAY;
         case (s_axi_araddr)
            REG_CTRL: next_r.rdata = ctrl_word;
            REG_RANGE_INT16: next_r.rdata = {r.hi[RANGE_INT16], r.lo[RANGE_INT16]};
            REG_RANGE_INT32: next_r.rdata = {r.hi[RANGE_INT32], r.lo[RANGE_INT32]};
            REG_RANGE_FLOAT: next_r.rdata = {r.hi[RANGE_FLOAT], r.lo[RANGE_FLOAT]};
            REG_BLOCKS: next_r.rdata = {8'h00, r.blk};
            REG_COUNTS: next_r.rdata = {8'h00, r.n_exc, r.n_drop, r.n_write};
            REG_LAST: next_r.rdata = {8'h00, r.last_blk, r.last_off};
            REG_MEM_ADDR: next_r.rdata = {24'h000000, r.mem_addr};
            REG_MEM_DATA: next_r.rdata = mem_rdata;
            default:
            begin
               next_r.rdata = '0;
               next_r.rresp = RESP_SLVERR;
            end
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (!reset_n)
         r <= REGS_RESET;
      else
         r <= next_r;
   end

   assign mem_we = (r.fsm == ST_WRITE);
   assign mem_waddr = {r.sel, r.off[OFF_WORD_LSB +: BLOCK_AW]};
   // high byte first, most significant first, no value check
   assign mem_be = (r.sel != RANGE_INT16) ? BE_FULL :
                   (r.off[OFF_HALF_BIT] ? BE_LOW_HALF : BE_HIGH_HALF);
   assign mem_wdata = (r.sel != RANGE_INT16) ?
      {r.frame[IDX_DATA], r.frame[IDX_DATA+1], r.frame[IDX_DATA+2], r.frame[IDX_DATA+3]} :
      {r.frame[IDX_DATA], r.frame[IDX_DATA+1], r.frame[IDX_DATA], r.frame[IDX_DATA+1]};

   lrc_sum u_lrc (
      .clk(clk),
      .reset_n(reset_n),
      .clear(r.fsm == ST_CHECK),
      .add(rx_hs),
      .data(rx_data),
      .sum(lrc)
   );

   storage_ram u_ram (
      .clk(clk),
      .reset_n(reset_n),
      .we(mem_we),
      .be(mem_be),
      .waddr(mem_waddr),
      .wdata(mem_wdata),
      .raddr(r.mem_addr),
      .rdata(mem_rdata)
   );

   assign rx_ready = (r.fsm == ST_COLLECT);
   assign tx_data = r.tx_data;
   assign tx_valid = r.tx_valid;
   assign tx_last = r.tx_valid && (r.tx_idx == r.tx_len - 4'h1);
   assign s_axi_awready = !r.aw_held && !r.bvalid;
   assign s_axi_wready = !r.w_held && !r.bvalid;
   assign s_axi_bvalid = r.bvalid;
   assign s_axi_bresp = r.bresp;
   assign s_axi_arready = !r.rvalid;
   assign s_axi_rvalid = r.rvalid;
   assign s_axi_rdata = r.rdata;
   assign s_axi_rresp = r.rresp;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   a_write_needs_frame: assert property (mem_we |-> $past(frame_ok))
      else $error("write without valid frame");
   a_write_in_range: assert property (mem_we |-> in_range(regnum, r.lo[r.sel], r.hi[r.sel]))
      else $error("write outside range");
   a_echo_len16: assert property (mem_we && r.sel == RANGE_INT16 |=> tx_valid && r.tx_len == LEN16)
      else $error("16-bit echo length wrong");
   a_echo_len32: assert property (mem_we && r.sel != RANGE_INT16 |=> tx_valid && r.tx_len == LEN32)
      else $error("32-bit echo length wrong");
   a_half_lane: assert property (mem_we && r.sel == RANGE_INT16 |-> mem_be == (r.off[OFF_HALF_BIT] ? BE_LOW_HALF : BE_HIGH_HALF) && r.off == {1'h0, regnum - r.lo[RANGE_INT16], 1'h0})
      else $error("16-bit lane or offset wrong");
   a_word_order: assert property (mem_we && r.sel != RANGE_INT16 |-> mem_be == BE_FULL && mem_wdata[31:24] == r.frame[IDX_DATA] && r.off == {regnum - r.lo[r.sel], 2'h0})
      else $error("32-bit order or offset wrong");
   a_exception_frame: assert property (r.fsm == ST_CHECK && frame_ok && hit == '0 |=> r.fsm == ST_REPLY && r.tx_len == EXC_LEN && r.frame[IDX_FUNC] == (FUNC_WRITE_SINGLE | EXC_FLAG) && !mem_we)
      else $error("exception reply wrong");
   a_drop_silent: assert property (r.fsm == ST_CHECK && !frame_ok |=> r.fsm == ST_COLLECT ##1 !tx_valid)
      else $error("bad frame not dropped");
   a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("bvalid dropped early");

   c_write16: cover property (mem_we && r.sel == RANGE_INT16);
   c_write_float: cover property (mem_we && r.sel == RANGE_FLOAT);
   c_exception: cover property (tx_last && r.tx_len == EXC_LEN && tx_ready);
   c_drop: cover property (r.fsm == ST_CHECK && !frame_ok);
endmodule // modbus_write_single_register_32bit

// >>> testbench/modbus_master_model.sv
// Purpose: Link master model, sends request bytes and collects replies
// Assumes: Same clock as the block, one binary byte per transfer
// Notes: slow makes tx_ready toggle so the reply stalls
`timescale 1ns/1ps
module modbus_master_model
(
   // Clock and pacing
   input wire logic clk,
   input wire logic slow,
   // Request bytes
   output logic [7:0] rx_data,
   output logic rx_valid,
   output logic rx_last,
   input wire logic rx_ready,
   // Reply bytes
   input wire logic [7:0] tx_data,
   input wire logic tx_valid,
   input wire logic tx_last,
   output logic tx_ready
);
   logic [7:0] got[$];
   int last_at = -1;
   initial
   begin
      rx_data = 8'h00;
      rx_valid = 1'b0;
      rx_last = 1'b0;
      tx_ready = 1'b1;
   end
   // whole frame in order, LRC last
   task automatic send(input logic [8:0][7:0] b, input int n);
      for (int i = 0; i < n; i++)
      begin
         @(posedge clk);
         rx_data <= b[i];
         rx_valid <= 1'b1;
         rx_last <= (i == n - 1);
         do @(negedge clk); while (rx_ready !== 1'b1);
      end
      @(posedge clk);
      rx_valid <= 1'b0;
      rx_last <= 1'b0;
      rx_data <= ~b[n-1];
   endtask
   // Collect reply, stall when slow
   always @(posedge clk)
   begin
      if (tx_valid && tx_ready)
      begin
         got.push_back(tx_data);
         if (tx_last) last_at = got.size() - 1;
      end
      tx_ready <= slow ? ~tx_ready : 1'b1;
   end
endmodule // modbus_master_model

// >>> testbench/modbus_write_single_register_32bit_tb.sv
// Purpose: Self-checking bench for the write-single-register block
// Assumes: Link master model on the request and reply byte ports
// Notes: Ordinary and exception-reply frames as table rows, awkward cases by hand after
`timescale 1ns/1ps
module modbus_write_single_register_32bit_tb
   import mbw_pkg::*;
;
   typedef struct {logic [15:0] r; logic [31:0] d; int n; logic exc; logic [7:0] ma;
      logic [31:0] msk; logic [31:0] dat; logic [31:0] lst;} row_t;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic slow = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00;
   logic [7:0] s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic [7:0] rx_data, tx_data;
   logic rx_valid, rx_last, rx_ready, tx_valid, tx_last, tx_ready;
   int n_fail = 0;
   int checks_done = 0;
   row_t rows[6];
   logic [7:0] ca[5] = '{REG_RANGE_INT16, REG_RANGE_INT32, REG_RANGE_FLOAT, REG_BLOCKS, REG_CTRL};
   logic [31:0] cd[5] = '{32'h13870ce4, 32'h13eb1388, 32'h270f1b58, 32'h00040302, 32'h00000501};

   modbus_write_single_register_32bit DUT (.clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_data, .rx_valid, .rx_last, .rx_ready,
      .tx_data, .tx_valid, .tx_last, .tx_ready);
   modbus_master_model mst (.clk, .slow, .rx_data, .rx_valid, .rx_last, .rx_ready, .tx_data,
      .tx_valid, .tx_last, .tx_ready);

   always #5 clk = ~clk;

   task automatic end_of_test();
      if (n_fail == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e)
      begin
         n_fail++;
         $display("BAD %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] er);
      logic pa, pw, pb;
      pa = 1'b1;
      pw = 1'b1;
      pb = 1'b1;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (pb)
      begin
         @(negedge clk);
         if (s_axi_awready) pa = 1'b0;
         if (s_axi_wready) pw = 1'b0;
         if (s_axi_bvalid) chk(s_axi_bresp, er);
         if (s_axi_bvalid) pb = 1'b0;
         @(posedge clk);
         s_axi_awvalid <= pa;
         s_axi_wvalid <= pw;
         s_axi_bready <= pb;
      end
   endtask
   task automatic axr(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
      logic pa, pr;
      logic [1:0] r;
      pa = 1'b1;
      pr = 1'b1;
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (pr)
      begin
         @(negedge clk);
         if (s_axi_arready) pa = 1'b0;
         if (s_axi_rvalid) pr = 1'b0;
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge clk);
         s_axi_arvalid <= pa;
         s_axi_rready <= pr;
      end
      chk(r, er);
   endtask
   task automatic mem(input logic [7:0] ma, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] d;
      axw(REG_MEM_ADDR, {24'h0, ma}, 4'hf, RESP_OKAY);
      repeat (2) @(posedge clk);
      axr(REG_MEM_DATA, d, RESP_OKAY);
      chk(d & m, e & m);
   endtask
   function automatic logic [8:0][7:0] frame(input logic [15:0] r, input logic [31:0] d,
                                             input int n);
      logic [7:0] s;
      frame = '0;
      frame[0] = 8'h05;
      frame[1] = FUNC_WRITE_SINGLE;
      frame[2] = r[15:8];
      frame[3] = r[7:0];
      for (int i = 0; i < n - 5; i++)
         frame[4+i] = d[8*(n-6-i) +: 8];
      // LRC is minus the byte sum
      s = 8'h00;
      for (int i = 0; i < n - 1; i++)
         s = s + frame[i];
      frame[n-1] = -s;
   endfunction
   task automatic xfer(input logic [8:0][7:0] f, input int n, input logic [8:0][7:0] e,
                       input int m);
      int t;
      mst.got.delete();
      mst.last_at = -1;
      mst.send(f, n);
      t = 0;
      while (mst.got.size() < m && t < 400)
      begin
         @(posedge clk);
         t++;
      end
      repeat (m == 0 ? 20 : 2) @(posedge clk);
      chk(mst.got.size(), m);
      for (int i = 0; i < m; i++)
         chk(mst.got[i], e[i]);
      if (m > 0) chk(mst.last_at, m - 1);
   endtask

   initial
   begin
      #400000;
      n_fail++;
      end_of_test();
   end

   initial
   begin
      logic [31:0] d;
      logic [8:0][7:0] f;
      logic [8:0][7:0] ex;
      ex = {40'h0, 8'h73, 8'h02, 8'h86, 8'h05};
      rows = '{
         '{16'h0d37, 32'h2b1a, 7, 0, 8'h29, 32'h0000ffff, 32'h00002b1a, 32'h000200a6},
         '{16'h0d36, 32'h5c3e, 7, 0, 8'h29, 32'hffffffff, 32'h5c3e2b1a, 32'h000200a4},
         '{16'h13c7, 32'hffffffff, 9, 0, 8'h7f, 32'hffffffff, 32'hffffffff, 32'h000300fc},
         '{16'h1b5a, 32'h12233445, 9, 0, 8'h82, 32'hffffffff, 32'h12233445, 32'h00040008},
         '{16'h0100, 32'h0, 7, 1, 8'h7f, 32'hffffffff, 32'hffffffff, 32'h00040008},
         '{16'h0db7, 32'h1111, 7, 1, 8'h29, 32'hffffffff, 32'h5c3e2b1a, 32'h00040008}};
      repeat (7) @(posedge clk);
      @(negedge clk);
      chk({rx_ready, tx_valid, s_axi_awready, s_axi_bvalid}, 4'ha);
      @(posedge clk);
      reset_n <= 1'b1;
      for (int i = 0; i < 5; i++)
      begin
         axw(ca[i], cd[i], 4'hf, RESP_OKAY);
         axr(ca[i], d, RESP_OKAY);
         chk(d, cd[i]);
      end
      foreach (rows[k])
      begin
         f = frame(rows[k].r, rows[k].d, rows[k].n);
         xfer(f, rows[k].n, rows[k].exc ? ex : f, rows[k].exc ? 4 : rows[k].n);
         mem(rows[k].ma, rows[k].msk, rows[k].dat);
         axr(REG_LAST, d, RESP_OKAY);
         chk(d, rows[k].lst);
      end
      axr(REG_COUNTS, d, RESP_OKAY);
      chk(d, 32'h00020004);
      f = frame(16'h0d37, 32'h2b1a, 7);
      f[6] = f[6] ^ 8'h01;
      xfer(f, 7, ex, 0);
      f = frame(16'h0d37, 32'h2b1a, 7);
      f[0] = 8'h07;
      f[6] = f[6] - 8'h02;
      xfer(f, 7, ex, 0);
      f = frame(16'h0d37, 32'h2b1a, 7);
      f[1] = 8'h03;
      f[6] = f[6] + 8'h03;
      xfer(f, 7, ex, 0);
      xfer(frame(16'h0d37, 32'h0, 9), 9, ex, 0);
      mem(8'h29, 32'hffffffff, 32'h5c3e2b1a);
      slow <= 1'b1;
      f = frame(16'h1b5b, 32'hcafe0001, 9);
      xfer(f, 9, f, 9);
      slow <= 1'b0;
      mem(8'h83, 32'hffffffff, 32'hcafe0001);
      axw(REG_CTRL, 32'h0, 4'h1, RESP_OKAY);
      axr(REG_CTRL, d, RESP_OKAY);
      chk(d, 32'h00000500);
      xfer(frame(16'h0d37, 32'h2b1a, 7), 7, ex, 0);
      axw(REG_COUNTS, 32'hffffffff, 4'hf, RESP_OKAY);
      axr(REG_COUNTS, d, RESP_OKAY);
      chk(d, 32'h00020505);
      axw(8'h40, 32'h1, 4'hf, RESP_SLVERR);
      axr(8'h40, d, RESP_SLVERR);
      chk(d, 32'h0);
      @(posedge clk);
      reset_n <= 1'b0;
      repeat (7) @(posedge clk);
      @(negedge clk);
      chk({rx_ready, tx_valid, s_axi_awready, s_axi_bvalid}, 4'ha);
      @(posedge clk);
      reset_n <= 1'b1;
      axr(REG_RANGE_INT16, d, RESP_OKAY);
      chk(d, 32'h0);
      xfer(frame(16'h0000, 32'h2b1a, 7), 7, ex, 0);
      end_of_test();
   end
endmodule // modbus_write_single_register_32bit_tb
